// ### logic/pcm_hw_pkg.sv
// Constants and helpers for the PCM highway input and output buffers
package pcm_hw_pkg;
    // Frame rate and device clock rates
    localparam int FRAME_HZ = 8000;
    localparam int FAST_CLK_KHZ = 8192;
    localparam int SLOW_CLK_KHZ = 4096;
    // Position counter width, half device clock periods
    localparam int POS_W = 11;
    localparam logic [10:0] MASK_FAST = 11'h7FF;
    localparam logic [10:0] MASK_SLOW = 11'h3FF;
    // Output frame lead before sync fall, in half periods
    localparam logic [10:0] LEAD_FAST = 11'h004;
    localparam logic [10:0] LEAD_SLOW = 11'h002;
    // Line rate codes
    localparam logic [1:0] RATE_OFF = 2'h0;
    localparam logic [1:0] RATE_2048 = 2'h1;
    localparam logic [1:0] RATE_4096 = 2'h2;
    localparam logic [1:0] RATE_8192 = 2'h3;
    // Setup register layout and reset value
    localparam int CFG_SEL_BIT = 0;
    localparam int CLK_SEL_BIT = 1;
    localparam logic [7:0] SETUP_RESET = 8'h01;
    // Frame shift control layout and reset value
    localparam int RX_SHIFT_LSB = 5;
    localparam int RX_HALF_BIT = 4;
    localparam int TX_SHIFT_LSB = 1;
    localparam int TX_HALF_BIT = 0;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    // Line mode codes, same index for input and output
    localparam logic [3:0] MODE_ALL_SLOW = 4'h0;
    localparam logic [3:0] MODE_ALL_MID = 4'h1;
    localparam logic [3:0] MODE_ALL_FAST = 4'h2;
    localparam logic [3:0] MODE_FAST_SLOW = 4'h3;
    localparam logic [3:0] MODE_MID_SLOW = 4'h4;

    // Rate of an input line for a mode
    function automatic logic [1:0] in_rate(logic [3:0] m, int l);
        unique case (m)
            MODE_ALL_MID: return (l < 8) ? RATE_4096 : RATE_OFF;
            MODE_ALL_FAST: return (l < 4) ? RATE_8192 : RATE_OFF;
            MODE_FAST_SLOW: return (l < 2) ? RATE_8192 :
                (l >= 8) ? RATE_2048 : RATE_OFF;
            MODE_MID_SLOW: return (l < 4) ? RATE_4096 :
                (l >= 8) ? RATE_2048 : RATE_OFF;
            default: return RATE_2048;
        endcase
    endfunction

    // Rate of an output line for a mode
    function automatic logic [1:0] out_rate(logic [3:0] m, int l);
        unique case (m)
            MODE_ALL_MID: return (l < 4) ? RATE_4096 : RATE_OFF;
            MODE_ALL_FAST: return (l < 2) ? RATE_8192 : RATE_OFF;
            MODE_FAST_SLOW: return (l < 1) ? RATE_8192 :
                (l >= 4) ? RATE_2048 : RATE_OFF;
            MODE_MID_SLOW: return (l < 2) ? RATE_4096 :
                (l >= 4) ? RATE_2048 : RATE_OFF;
            default: return RATE_2048;
        endcase
    endfunction
endpackage

// ### logic/pcm_highway_io_buffers.sv
// Serial PCM highway input and output buffers with write FIFO

// Word FIFO between the input buffer and the speech memory
module pcm_word_fifo #(
    parameter int WIDTH = 17,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Filling side
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    // Draining side
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = DEPTH[AW:0];

    logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
    logic [AW-1:0] wr_ptr; // Next slot to fill
    logic [AW-1:0] rd_ptr; // Oldest word
    logic [AW:0] count; // Words held
    logic push;
    logic pop;

    assign o_in_ready = (count != FULL_CNT);
    assign o_out_valid = (count != '0);
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr];

    // Storage write
    always_ff @(posedge i_sys_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // Pointers and fill level
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

// Input and output buffers of the memory time switch
module pcm_highway_io_buffers (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_srst,
    // Device clock and frame sync pins
    input wire logic i_dev_clk,
    input wire logic i_frame_sync_pulse,
    // Serial highway lines
    input wire logic [15:0] i_pcm_in,
    output logic [7:0] o_pcm_out,
    output logic [7:0] o_pcm_oe,
    // Line setup from the mode register
    input wire logic [3:0] i_line_setup,
    // Setup register access
    input wire logic i_setup_wr,
    input wire logic [7:0] i_setup_wdata,
    output logic [7:0] o_setup_register,
    // Frame shift control access
    input wire logic i_fsc_wr,
    input wire logic [7:0] i_fsc_wdata,
    output logic [7:0] o_frame_shift_control,
    // Speech memory write port
    output logic o_sm_wr_valid,
    input wire logic i_sm_wr_ready,
    output logic [8:0] o_sm_wr_addr,
    output logic [7:0] o_sm_wr_data,
    // Output channel fetch, answer in the same cycle as request
    output logic o_rd_req,
    output logic [7:0] o_rd_chan,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_tristate
);
    logic [7:0] setup_register; // Configuration bits
    logic [7:0] frame_shift_control; // Clock shift bits
    logic std_cfg; // Standard configuration active
    logic fast_clk; // 8192 kHz device clock
    logic [10:0] mask; // Frame length mask
    logic [2:0] rx_shift;
    logic rx_half;
    logic [2:0] tx_shift;
    logic tx_half;
    logic mixed; // Two rates in use

    // Pin synchronisers, first stage read only by second
    logic clk_s1, clk_s2, clk_s3;
    logic sync_s1, sync_s2;
    logic [15:0] din_s1, din_s2;
    logic sync_prev; // Sync level at last rising clock
    logic dev_rise, dev_fall, dev_edge;
    logic ev_d; // Edge seen, counters already advanced
    logic [10:0] pos; // Half periods since sync rise
    logic [10:0] out_pos; // Standard output frame position

    assign o_setup_register = setup_register;
    assign o_frame_shift_control = frame_shift_control;
    assign std_cfg = setup_register[pcm_hw_pkg::CFG_SEL_BIT];
    assign fast_clk = setup_register[pcm_hw_pkg::CLK_SEL_BIT];
    assign mask = fast_clk ? pcm_hw_pkg::MASK_FAST
                           : pcm_hw_pkg::MASK_SLOW;
    assign rx_shift = frame_shift_control[pcm_hw_pkg::RX_SHIFT_LSB +: 3];
    assign rx_half = frame_shift_control[pcm_hw_pkg::RX_HALF_BIT];
    assign tx_shift = frame_shift_control[pcm_hw_pkg::TX_SHIFT_LSB +: 3];
    assign tx_half = frame_shift_control[pcm_hw_pkg::TX_HALF_BIT];
    assign mixed = (i_line_setup == pcm_hw_pkg::MODE_FAST_SLOW) ||
                   (i_line_setup == pcm_hw_pkg::MODE_MID_SLOW);

    // Setup register, standard configuration after reset
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            setup_register <= pcm_hw_pkg::SETUP_RESET;
        end else if (i_setup_wr) begin
            setup_register <= i_setup_wdata;
        end
    end

    // Shift control, held clear while standard is selected
    always_ff @(posedge i_sys_clk) begin
        if (i_srst || std_cfg) begin
            frame_shift_control <= pcm_hw_pkg::SHIFT_RESET;
        end else if (i_fsc_wr) begin
            frame_shift_control <= i_fsc_wdata;
        end
    end

    // Two-flop synchronisers for every pin input
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            clk_s1 <= 1'b0;
            clk_s2 <= 1'b0;
            clk_s3 <= 1'b0;
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            din_s1 <= 16'h0000;
            din_s2 <= 16'h0000;
        end else begin
            clk_s1 <= i_dev_clk;
            clk_s2 <= clk_s1;
            clk_s3 <= clk_s2;
            sync_s1 <= i_frame_sync_pulse;
            sync_s2 <= sync_s1;
            din_s1 <= i_pcm_in;
            din_s2 <= din_s1;
        end
    end

    // Device clock edges as one-cycle enables
    assign dev_rise = clk_s2 && !clk_s3;
    assign dev_fall = !clk_s2 && clk_s3;
    assign dev_edge = dev_rise || dev_fall;

    // Frame counters on device clock edges, reloaded by sync
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            sync_prev <= 1'b0;
            pos <= 11'h000;
            out_pos <= 11'h000;
            ev_d <= 1'b0;
        end else begin
            ev_d <= dev_edge;
            if (dev_rise) begin
                sync_prev <= sync_s2;
            end
            if (dev_rise && sync_s2 && !sync_prev) begin
                pos <= 11'h000;
            end else if (dev_edge) begin
                pos <= (pos + 11'h001) & mask;
            end
            // Output frame started a fixed lead before sync fall
            if (dev_rise && !sync_s2 && sync_prev) begin
                out_pos <= fast_clk ? pcm_hw_pkg::LEAD_FAST
                                    : pcm_hw_pkg::LEAD_SLOW;
            end else if (dev_edge) begin
                out_pos <= (out_pos + 11'h001) & mask;
            end
        end
    end

    // Input buffer state per line
    logic [15:0] in_pend; // Byte waiting for the FIFO
    logic [15:0] in_grant; // Line taken by the FIFO
    logic [7:0] in_byte [16];
    logic [8:0] in_addr [16];
    logic fifo_ready;
    logic fifo_push;
    logic [16:0] fifo_word;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_in
            logic [1:0] rate;
            logic [1:0] k; // Log2 of half periods per bit
            logic live; // Line in use and rate legal
            logic shifted; // Odd line under primary timing
            logic [10:0] adv;
            logic [10:0] dly;
            logic [10:0] p;
            logic [10:0] off;
            logic [10:0] smp;
            logic [9:0] bitn;
            logic [7:0] sr; // Serial to parallel shifter

            // Bit timing of this input line
            always_comb begin
                rate = pcm_hw_pkg::in_rate(i_line_setup, gi);
                k = 2'(3'(fast_clk) + 3'h3 - 3'(rate));
                // Fast line on slow clock is left idle
                live = (rate != pcm_hw_pkg::RATE_OFF) &&
                       (k != 2'h0);
                shifted = !std_cfg && (gi % 2 == 1);
                adv = shifted ? (11'(rx_shift) << k) : 11'h000;
                dly = (shifted && rx_half) ? (11'h001 << (k - 2'h1))
                                           : 11'h000;
                p = (pos + adv - dly) & mask;
                off = p & ((11'h001 << k) - 11'h001);
                bitn = 10'(p >> k);
                // Mid-bit sampling, except late for slow lines without half shift
                if (rate != pcm_hw_pkg::RATE_2048 ||
                    (shifted && rx_half)) begin
                    smp = 11'h001 << (k - 2'h1);
                end else begin
                    smp = 11'h003 << (k - 2'h2);
                end
            end

            // Shift in MSB first, hand over each full byte
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    sr <= 8'h00;
                    in_pend[gi] <= 1'b0;
                    in_byte[gi] <= 8'h00;
                    in_addr[gi] <= 9'h000;
                end else begin
                    if (ev_d && live && off == smp) begin
                        sr <= {sr[6:0], din_s2[gi]};
                    end
                    // A new byte wins over the grant
                    if (ev_d && live && off == smp &&
                        bitn[2:0] == 3'h7) begin
                        in_pend[gi] <= 1'b1;
                        in_byte[gi] <= {sr[6:0], din_s2[gi]};
                        unique case (rate)
                            pcm_hw_pkg::RATE_2048: in_addr[gi] <= mixed ?
                                {1'b1, bitn[7:3], 3'(gi)} :
                                {bitn[7:3], 4'(gi)};
                            pcm_hw_pkg::RATE_4096: in_addr[gi] <= mixed ?
                                {1'b0, bitn[8:3], 2'(gi)} :
                                {bitn[8:3], 3'(gi)};
                            default: in_addr[gi] <= mixed ?
                                {1'b0, bitn[9:3], 1'(gi)} :
                                {bitn[9:3], 2'(gi)};
                        endcase
                    end else if (in_grant[gi]) begin
                        in_pend[gi] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Lowest pending line goes to the FIFO when it has room
    always_comb begin
        in_grant = 16'h0000;
        fifo_word = 17'h00000;
        for (int i = 15; i >= 0; i--) begin
            if (in_pend[i] && fifo_ready) begin
                in_grant = 16'h0000;
                in_grant[i] = 1'b1;
                fifo_word = {in_addr[i], in_byte[i]};
            end
        end
    end
    assign fifo_push = (in_grant != 16'h0000);

    // Write buffer toward the speech memory
    pcm_word_fifo #(
        .WIDTH(17),
        .DEPTH(16)
    ) u_fifo (
        .i_sys_clk(i_sys_clk),
        .i_srst(i_srst),
        .i_in_valid(fifo_push),
        .o_in_ready(fifo_ready),
        .i_in_data(fifo_word),
        .o_out_valid(o_sm_wr_valid),
        .i_out_ready(i_sm_wr_ready),
        .o_out_data({o_sm_wr_addr, o_sm_wr_data})
    );

    // Output buffer state per line
    logic [7:0] out_pend; // Fetch for next slot wanted
    logic [7:0] out_take; // Fetch issued this cycle
    logic [7:0] out_chan [8];
    logic [7:0] nbyte [8]; // Byte for the next slot
    logic [7:0] ntri; // Tristate flag for the next slot
    logic [2:0] pick; // Line chosen this cycle
    logic [2:0] rd_line; // Line whose answer is due
    logic rd_due; // Answer arrives this cycle

    genvar go;
    generate
        for (go = 0; go < 8; go++) begin : g_out
            logic [1:0] rate;
            logic [1:0] k;
            logic live;
            logic [10:0] lag;
            logic [10:0] q;
            logic [10:0] off;
            logic [9:0] bitn;
            logic [6:0] nslot;
            logic [7:0] sh; // Byte being sent
            logic tri_now; // Current slot tristated

            // Bit timing of this output line
            always_comb begin
                rate = pcm_hw_pkg::out_rate(i_line_setup, go);
                k = 2'(3'(fast_clk) + 3'h3 - 3'(rate));
                live = (rate != pcm_hw_pkg::RATE_OFF) && (k != 2'h0);
                // Even lines in primary access lag the sync rise
                if (!std_cfg && go % 2 == 0) begin
                    lag = (tx_shift == 3'h0) ? 11'h000 :
                        (11'(4'h8 - 4'(tx_shift)) << k);
                    lag = lag + 11'(tx_half);
                    q = (pos - lag) & mask;
                end else if (!std_cfg) begin
                    q = pos;
                    lag = 11'h000;
                end else begin
                    q = out_pos;
                    lag = 11'h000;
                end
                off = q & ((11'h001 << k) - 11'h001);
                bitn = 10'(q >> k);
                nslot = bitn[9:3] + 7'h01;
            end

            // Drive each bit at the start of its period
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    sh <= 8'h00;
                    tri_now <= 1'b1;
                    o_pcm_out[go] <= 1'b0;
                    o_pcm_oe[go] <= 1'b0;
                end else if (!live) begin
                    o_pcm_oe[go] <= 1'b0;
                end else if (ev_d && off == 11'h000) begin
                    if (bitn[2:0] == 3'h0) begin
                        sh <= nbyte[go];
                        tri_now <= ntri[go];
                        o_pcm_out[go] <= nbyte[go][7];
                        o_pcm_oe[go] <= !ntri[go];
                    end else begin
                        o_pcm_out[go] <= sh[3'h7 - bitn[2:0]];
                        o_pcm_oe[go] <= !tri_now;
                    end
                end
            end

            // Ask for the next slot half a byte ahead
            always_ff @(posedge i_sys_clk) begin
                if (i_srst) begin
                    out_pend[go] <= 1'b0;
                    out_chan[go] <= 8'h00;
                end else if (live && ev_d && off == 11'h000 &&
                             bitn[2:0] == 3'h4) begin
                    out_pend[go] <= 1'b1;
                    unique case (rate)
                        pcm_hw_pkg::RATE_2048: out_chan[go] <= mixed ?
                            {1'b1, nslot[4:0], 2'(go)} :
                            {nslot[4:0], 3'(go)};
                        pcm_hw_pkg::RATE_4096: out_chan[go] <= mixed ?
                            {1'b0, nslot[5:0], 1'(go)} :
                            {nslot[5:0], 2'(go)};
                        default: out_chan[go] <= mixed ?
                            {1'b0, nslot[6:0]} :
                            {nslot[6:0], 1'(go)};
                    endcase
                end else if (out_take[go]) begin
                    out_pend[go] <= 1'b0;
                end
            end
        end
    endgenerate

    // Lowest pending output line gets the fetch slot
    always_comb begin
        out_take = 8'h00;
        pick = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (out_pend[i]) begin
                out_take = 8'h00;
                out_take[i] = 1'b1;
                pick = 3'(i);
            end
        end
    end

    // Fetch request, one per cycle, registered
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            o_rd_req <= 1'b0;
            o_rd_chan <= 8'h00;
            rd_line <= 3'h0;
            rd_due <= 1'b0;
        end else begin
            o_rd_req <= (out_take != 8'h00);
            rd_due <= (out_take != 8'h00);
            if (out_take != 8'h00) begin
                o_rd_chan <= out_chan[pick];
                rd_line <= pick;
            end
        end
    end

    // Capture byte and validity bit at the edge ending the request cycle
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            for (int i = 0; i < 8; i++) begin
                nbyte[i] <= 8'h00;
            end
            ntri <= 8'hFF;
        end else if (rd_due) begin
            nbyte[rd_line] <= i_rd_data;
            ntri[rd_line] <= i_rd_tristate;
        end
    end
endmodule

// ### dv/pcm_highway_io_buffers_chk.sv
// Port checker for the PCM highway buffers
module pcm_hw_chk (
    // Clock, reset and register writes
    input wire logic i_sys_clk,
    input wire logic i_srst,
    input wire logic i_setup_wr,
    input wire logic [7:0] i_setup_wdata,
    input wire logic i_fsc_wr,
    input wire logic [7:0] i_fsc_wdata,
    // Observed outputs
    input wire logic [7:0] o_setup_register,
    input wire logic [7:0] o_frame_shift_control,
    input wire logic [7:0] o_pcm_oe,
    input wire logic o_rd_req,
    input wire logic o_sm_wr_valid,
    input wire logic i_sm_wr_ready,
    input wire logic [8:0] o_sm_wr_addr,
    input wire logic [7:0] o_sm_wr_data
);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);
    // Reset checks override the default disable
    a_reset_setup: assert property (disable iff (1'b0)
        i_srst |=> o_setup_register == 8'h01) else $error("setup reset");
    a_reset_shift: assert property (disable iff (1'b0)
        i_srst |=> o_frame_shift_control == 8'h00) else $error("shift reset");
    a_reset_quiet: assert property (disable iff (1'b0)
        i_srst |=> o_pcm_oe == 8'h00 && !o_sm_wr_valid && !o_rd_req)
        else $error("outputs active in reset");
    // Standard mode holds the shift control at zero
    a_std_clear: assert property (
        o_setup_register[0] && $past(o_setup_register[0])
        |-> o_frame_shift_control == 8'h00) else $error("shift not clear");
    a_shift_write: assert property (
        i_fsc_wr && !i_setup_wr && !o_setup_register[0]
        |=> o_frame_shift_control == $past(i_fsc_wdata))
        else $error("shift write lost");
    a_setup_write: assert property (
        i_setup_wr |=> o_setup_register[1:0] == $past(i_setup_wdata[1:0]))
        else $error("setup write lost");
    a_shift_hold: assert property (
        !i_fsc_wr && !i_setup_wr && !$past(i_setup_wr)
        |=> $stable(o_frame_shift_control)) else $error("shift changed");
    // Stalled word must stand unchanged
    a_fifo_hold: assert property (
        o_sm_wr_valid && !i_sm_wr_ready |=> o_sm_wr_valid
        && $stable(o_sm_wr_addr) && $stable(o_sm_wr_data))
        else $error("word dropped in stall");
    c_stall: cover property (o_sm_wr_valid && !i_sm_wr_ready);
    c_primary: cover property (i_fsc_wr && !o_setup_register[0]);
    c_drive: cover property (o_pcm_oe != 8'h00);
endmodule
bind pcm_highway_io_buffers pcm_hw_chk u_chk (.i_sys_clk(i_sys_clk),
    .i_srst(i_srst), .i_setup_wr(i_setup_wr),
    .i_setup_wdata(i_setup_wdata), .i_fsc_wr(i_fsc_wr),
    .i_fsc_wdata(i_fsc_wdata), .o_setup_register(o_setup_register),
    .o_frame_shift_control(o_frame_shift_control), .o_pcm_oe(o_pcm_oe),
    .o_rd_req(o_rd_req), .o_sm_wr_valid(o_sm_wr_valid),
    .i_sm_wr_ready(i_sm_wr_ready), .o_sm_wr_addr(o_sm_wr_addr),
    .o_sm_wr_data(o_sm_wr_data));

// ### dv/pcm_line_model.sv
// Far-side line model: clock, sync, serial inputs, fetch answers
module pcm_line_model (
    // Fetch side
    input wire logic i_sys_clk,
    input wire logic i_rd_req,
    input wire logic [7:0] i_rd_chan,
    output logic [7:0] o_rd_data,
    output logic o_rd_tristate,
    // Highway pins
    output logic o_dev_clk,
    output logic o_sync,
    output logic [15:0] o_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [8:0] cyc; // Device clock cycle in frame
    logic [7:0] b; // Byte of the current slot
    logic [7:0] junk = 8'hA5; // Garbage shown between answers
    // Slow device clock, free running
    initial begin
        o_dev_clk = 1'b0;
        o_sync = 1'b0;
        o_line = 16'h0000;
        cyc = 9'h1FF;
        forever #122.07 o_dev_clk = ~o_dev_clk;
    end
    // Sync set half a cycle early so it is settled at the frame edge
    always @(negedge o_dev_clk) begin
        o_sync <= (cyc == 9'h1FF);
    end
    // 512 cycles a frame; 2048 kbit/s bits, slot number in low bits
    always @(posedge o_dev_clk) begin
        cyc = cyc + 9'h001;
        b = {3'h5, cyc[8:4]};
        o_line = {16{b[3'h7 - cyc[3:1]]}};
    end
    // Garbage changes every cycle so a late capture shows up
    always @(posedge i_sys_clk) begin
        junk <= ~junk;
    end
    // Answer stands with the request, taken at the edge ending it
    always_comb begin
        o_rd_data = i_rd_req ? i_rd_chan : junk;
        o_rd_tristate = i_rd_req ? i_rd_chan[0] : junk[0];
    end
endmodule

// ### dv/test_pcm_highway_io_buffers.sv
// Self-checking bench for the PCM highway buffers
module test_pcm_highway_io_buffers;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk, i_srst, dclk, sync, setup_wr, fsc_wr, ready, rd_req;
    logic tri_n, valid;
    logic [15:0] pins;
    logic [7:0] wdata, pout, oe, setup, fsc, chan, rd_data, wr_data;
    logic [8:0] wr_addr;
    logic [3:0] mode;
    logic [7:0] oe_seen; // Lines seen driving
    logic [7:0] out_seen; // Driven lines seen carrying a one
    int nwr; // Words taken
    int miscompares = 0;
    int tests_run = 0;
    // Output lines idle per mode at slow clock
    localparam logic [7:0] IDLE [5] = '{8'h00, 8'hF0, 8'hFF, 8'h0F, 8'h0C};
    pcm_highway_io_buffers uut (.i_sys_clk(i_sys_clk), .i_srst(i_srst),
        .i_dev_clk(dclk), .i_frame_sync_pulse(sync), .i_pcm_in(pins),
        .o_pcm_out(pout), .o_pcm_oe(oe), .i_line_setup(mode),
        .i_setup_wr(setup_wr), .i_setup_wdata(wdata),
        .o_setup_register(setup), .i_fsc_wr(fsc_wr), .i_fsc_wdata(wdata),
        .o_frame_shift_control(fsc), .o_sm_wr_valid(valid),
        .i_sm_wr_ready(ready), .o_sm_wr_addr(wr_addr),
        .o_sm_wr_data(wr_data), .o_rd_req(rd_req), .o_rd_chan(chan),
        .i_rd_data(rd_data), .i_rd_tristate(tri_n));
    pcm_line_model lines (.i_sys_clk(i_sys_clk), .i_rd_req(rd_req),
        .i_rd_chan(chan), .o_rd_data(rd_data), .o_rd_tristate(tri_n),
        .o_dev_clk(dclk), .o_sync(sync), .o_line(pins));
    initial begin
        i_sys_clk = 1'b0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end
    // Compare and count
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // One register write, then both registers read back
    task automatic reg_wr(input logic sel, input logic [7:0] d,
        input logic [7:0] es, input logic [7:0] ef);
        @(posedge i_sys_clk);
        setup_wr <= !sel;
        fsc_wr <= sel;
        wdata <= d;
        @(posedge i_sys_clk);
        setup_wr <= 1'b0;
        fsc_wr <= 1'b0;
        repeat (2) @(negedge i_sys_clk);
        check({setup, fsc}, {es, ef});
    endtask
    // Watch lines and memory writes; data checks in mode 0 only
    task automatic observe(input int n, input int m);
        for (int i = 0; i < n; i++) begin
            @(negedge i_sys_clk);
            oe_seen |= oe;
            out_seen |= pout & oe;
            if (valid && ready) begin
                nwr++;
                if (m == 0) begin
                    check(wr_data, {3'h5, wr_addr[8:4]});
                end
            end
        end
    endtask
    task automatic tally_and_finish;
        if (miscompares == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        i_srst = 1'b1;
        {setup_wr, fsc_wr, wdata, mode} = '0;
        ready = 1'b1;
        repeat (4) @(posedge i_sys_clk);
        i_srst <= 1'b0;
        @(negedge i_sys_clk);
        check({setup, fsc}, 16'h0100);
        reg_wr(1'b1, 8'hC0, 8'h01, 8'h00);
        reg_wr(1'b0, 8'h00, 8'h00, 8'h00);
        reg_wr(1'b1, 8'hC0, 8'h00, 8'hC0);
        reg_wr(1'b1, 8'h0D, 8'h00, 8'h0D);
        reg_wr(1'b0, 8'h01, 8'h01, 8'h00);
        for (int m = 0; m < 5; m++) begin
            @(posedge i_sys_clk);
            mode <= 4'(m);
            observe(3200, 9);
            oe_seen = 8'h00;
            out_seen = 8'h00;
            nwr = 0;
            // Stall the memory side for 400 cycles, then drain
            @(posedge i_sys_clk);
            ready <= 1'b0;
            observe(400, m);
            @(posedge i_sys_clk);
            ready <= 1'b1;
            for (int k = 0; k < 300 && valid; k++) observe(1, m);
            check(valid, 1'b0);
            observe(3200, m);
            check(oe_seen & IDLE[m], 8'h00);
            check(nwr != 0, m != 2);
            if (m == 0) begin
                check(oe_seen, 8'h55);
                check(out_seen, 8'h55);
            end
        end
        // Primary access, receive nibble zero: odd inputs as even
        reg_wr(1'b0, 8'h00, 8'h00, 8'h00);
        reg_wr(1'b1, 8'h0D, 8'h00, 8'h0D);
        @(posedge i_sys_clk);
        mode <= 4'h0;
        observe(3200, 9);
        oe_seen = 8'h00;
        out_seen = 8'h00;
        nwr = 0;
        observe(3200, 0);
        check(nwr != 0, 1'b1);
        check(oe_seen, 8'h55);
        check(out_seen, 8'h55);
        tally_and_finish();
    end
endmodule
